// ==== logic/sfp_consts.vh ====
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

// command codes
`define SFP_OP_ERASE_64K 8'hD8
`define SFP_OP_ERASE_32K 8'h52
`define SFP_OP_ERASE_4K 8'h20
`define SFP_OP_CHIP_ERASE 8'hC7
`define SFP_OP_PROGRAM 8'h02
`define SFP_OP_DUAL_PROGRAM 8'hA2
`define SFP_OP_READ 8'h03
`define SFP_OP_DUAL_READ 8'h3B
`define SFP_OP_PROTECT 8'h36
`define SFP_OP_UNPROTECT 8'h39

// array operation kinds on op_kind
`define SFP_KIND_ERASE_64K 3'h0
`define SFP_KIND_ERASE_32K 3'h1
`define SFP_KIND_ERASE_4K 3'h2
`define SFP_KIND_CHIP_ERASE 3'h3
`define SFP_KIND_PROGRAM 3'h4

// geometry and layout
`define SFP_ADDR_W 24
`define SFP_SECTORS 32
`define SFP_SECT_LSB 16
`define SFP_SECT_MSB 20
`define SFP_DUMMY_BITS 3'h7

// reset values
`define SFP_PROT_RST 1'h1
// pin synchronisers: {wp_n, hold_n, so, si, sck, cs_n}
`define SFP_SYNC_RST 6'h31

`endif

// ==== logic/sfp_pair_buf.v ====
`default_nettype none

module sfp_pair_buf #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire rst_sync_n,
  input wire clk_en,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] head;
  reg [W-1:0] tail;
  reg [1:0] fill;
  wire push;
  wire pop;

  assign in_ready = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data = head;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      head <= {W{1'b0}};
      tail <= {W{1'b0}};
      fill <= 2'h0;
    end else if (clk_en) begin
      if (push && pop) begin
        if (fill == 2'h1) begin
          head <= in_data;
        end else begin
          head <= tail;
          tail <= in_data;
        end
      end else if (push) begin
        if (fill == 2'h0) begin
          head <= in_data;
        end else begin
          tail <= in_data;
        end
        fill <= fill + 2'h1;
      end else if (pop) begin
        head <= tail;
        fill <= fill - 2'h1;
      end
    end
  end

endmodule // sfp_pair_buf

`default_nettype wire

// ==== logic/sfp_flash_pins.v ====
`include "sfp_consts.vh"
`default_nettype none

module sfp_flash_pins (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire cs_n,
  input wire sck,
  input wire si_in,
  output reg si_out,
  output wire si_oe,
  input wire so_in,
  output reg so_out,
  output wire so_oe,
  input wire hold_n,
  input wire wp_n,
  output reg op_valid,
  input wire op_ready,
  output reg [2:0] op_kind,
  output reg [23:0] op_addr,
  input wire array_busy,
  output wire wr_valid,
  input wire wr_ready,
  output wire [7:0] wr_data,
  output reg rd_req,
  output reg [23:0] rd_addr,
  input wire rd_valid,
  input wire [7:0] rd_data,
  output wire [31:0] sector_prot,
  output reg prot_fault,
  output reg wr_overrun
);

  localparam [2:0] ST_CMD = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DUMMY = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_IDLE = 3'h5;
  localparam [5:0] SYNC_RST = `SFP_SYNC_RST;

  reg [1:0] rst_pipe;
  wire rst_sync_n;
  wire [5:0] pin_raw;
  wire [5:0] pin_s;
  wire cs_s;
  wire sck_s;
  wire si_s;
  wire so_s;
  wire hold_s;
  wire wp_s;
  reg sck_d;
  reg cs_d;
  reg hold_act;
  wire sel;
  wire rise;
  wire fall;
  wire cs_fall;
  wire cs_rise;
  reg [2:0] state;
  reg [7:0] cmd;
  reg [7:0] shreg;
  reg [2:0] rx_cnt;
  reg [1:0] abyte;
  reg [23:0] addr;
  reg armed;
  reg prog_ok;
  reg [7:0] tx_shift;
  reg [2:0] tx_cnt;
  reg [7:0] rd_buf;
  reg drv;
  reg push_valid;
  reg [7:0] push_data;
  wire push_ready;
  wire dual_in;
  wire dual_out;
  wire wide;
  wire [7:0] nb;
  wire byte_done;
  wire [2:0] rx_step;
  wire [23:0] full_addr;
  wire [4:0] sect;
  wire [4:0] new_sect;
  wire [7:0] tx_byte;
  wire prot_wr;
  wire prot_val;
  wire is_erase;
  wire is_prog;
  wire is_op;
  wire target_prot;

  // reset asserts at once, releases through two flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  assign pin_raw = {wp_n, hold_n, so_in, si_in, sck, cs_n};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      reg meta;
      reg stable;
      always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          meta <= SYNC_RST[gi];
          stable <= SYNC_RST[gi];
        end else if (clk_en) begin
          meta <= pin_raw[gi];
          stable <= meta;
        end
      end
      assign pin_s[gi] = stable;
    end
  endgenerate

  assign cs_s = pin_s[0];
  assign sck_s = pin_s[1];
  assign si_s = pin_s[2];
  assign so_s = pin_s[3];
  assign hold_s = pin_s[4];
  assign wp_s = pin_s[5];

  assign sel = ~cs_s;
  // edge gate: clock ignored in hold
  assign rise = sel & ~hold_act & sck_s & ~sck_d;
  assign fall = sel & ~hold_act & ~sck_s & sck_d;
  assign cs_fall = cs_d & ~cs_s;
  assign cs_rise = ~cs_d & cs_s;

  assign dual_in = (cmd == `SFP_OP_DUAL_PROGRAM);
  assign dual_out = (cmd == `SFP_OP_DUAL_READ);
  assign wide = dual_in && (state == ST_WDATA);
  assign nb = wide ? {shreg[5:0], so_s, si_s} : {shreg[6:0], si_s};
  assign rx_step = wide ? 3'h2 : 3'h1;
  assign byte_done = wide ? (rx_cnt == 3'h6) : (rx_cnt == 3'h7);
  assign full_addr = {addr[15:0], nb};
  assign sect = addr[`SFP_SECT_MSB:`SFP_SECT_LSB];
  assign new_sect = full_addr[`SFP_SECT_MSB:`SFP_SECT_LSB];
  assign tx_byte = (tx_cnt == 3'h0) ? rd_buf : tx_shift;

  assign is_erase = (cmd == `SFP_OP_ERASE_64K) || (cmd == `SFP_OP_ERASE_32K) ||
                    (cmd == `SFP_OP_ERASE_4K) || (cmd == `SFP_OP_CHIP_ERASE);
  assign is_prog = (cmd == `SFP_OP_PROGRAM) || dual_in;
  assign is_op = is_erase || is_prog;
  assign target_prot = (cmd == `SFP_OP_CHIP_ERASE) ? (|sector_prot) : sector_prot[sect];
  assign prot_wr = cs_rise & armed &
                   ((cmd == `SFP_OP_PROTECT) | ((cmd == `SFP_OP_UNPROTECT) & wp_s));
  assign prot_val = (cmd == `SFP_OP_PROTECT);

  generate
    for (gi = 0; gi < `SFP_SECTORS; gi = gi + 1) begin : g_prot
      reg locked;
      always @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          locked <= `SFP_PROT_RST;
        end else if (clk_en && prot_wr && (sect == gi)) begin
          locked <= prot_val;
        end
      end
      assign sector_prot[gi] = locked;
    end
  endgenerate

  // hold begins only selected with clock low
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
      hold_act <= 1'b0;
    end else if (clk_en) begin
      sck_d <= sck_s;
      cs_d <= cs_s;
      if (!sel) begin
        hold_act <= 1'b0;
      end else if (!hold_act && !hold_s && !sck_s) begin
        hold_act <= 1'b1;
      end else if (hold_act && hold_s && !sck_s) begin
        hold_act <= 1'b0;
      end
    end
  end

  // receive path, framed by chip select
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      cmd <= 8'h00;
      shreg <= 8'h00;
      rx_cnt <= 3'h0;
      abyte <= 2'h0;
      addr <= 24'h000000;
      armed <= 1'b0;
      prog_ok <= 1'b0;
      push_valid <= 1'b0;
      push_data <= 8'h00;
    end else if (clk_en) begin
      push_valid <= 1'b0;
      if (cs_fall) begin
        state <= ST_CMD;
        cmd <= 8'h00;
        rx_cnt <= 3'h0;
        abyte <= 2'h0;
        armed <= 1'b0;
        prog_ok <= 1'b0;
      end else if (rise) begin
        // counters only move on live edges
        shreg <= nb;
        rx_cnt <= rx_cnt + rx_step;
        case (state)
          ST_CMD: begin
            if (byte_done) begin
              cmd <= nb;
              if (nb == `SFP_OP_CHIP_ERASE) begin
                armed <= 1'b1;
                state <= ST_IDLE;
              end else if ((nb == `SFP_OP_ERASE_64K) || (nb == `SFP_OP_ERASE_32K) ||
                           (nb == `SFP_OP_ERASE_4K) || (nb == `SFP_OP_PROGRAM) ||
                           (nb == `SFP_OP_DUAL_PROGRAM) || (nb == `SFP_OP_READ) ||
                           (nb == `SFP_OP_DUAL_READ) || (nb == `SFP_OP_PROTECT) ||
                           (nb == `SFP_OP_UNPROTECT)) begin
                state <= ST_ADDR;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ADDR: begin
            if (byte_done) begin
              addr <= full_addr;
              abyte <= abyte + 2'h1;
              if (abyte == 2'h2) begin
                if (cmd == `SFP_OP_READ) begin
                  state <= ST_RDATA;
                end else if (dual_out) begin
                  state <= ST_DUMMY;
                end else if (is_prog) begin
                  state <= ST_WDATA;
                  armed <= 1'b1;
                  prog_ok <= ~sector_prot[new_sect] & ~array_busy;
                end else begin
                  state <= ST_IDLE;
                  armed <= 1'b1;
                end
              end
            end
          end
          ST_DUMMY: begin
            if (rx_cnt == `SFP_DUMMY_BITS) begin
              state <= ST_RDATA;
            end
          end
          ST_WDATA: begin
            if (byte_done && prog_ok) begin
              push_valid <= 1'b1;
              push_data <= nb;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      so_out <= 1'b0;
      si_out <= 1'b0;
      tx_shift <= 8'h00;
      tx_cnt <= 3'h0;
      drv <= 1'b0;
      rd_req <= 1'b0;
      rd_addr <= 24'h000000;
      rd_buf <= 8'h00;
    end else if (clk_en) begin
      rd_req <= 1'b0;
      if (rd_valid) begin
        rd_buf <= rd_data;
      end
      if (cs_fall) begin
        tx_cnt <= 3'h0;
        drv <= 1'b0;
      end else if (rise && (state == ST_ADDR) && byte_done && (abyte == 2'h2) &&
                   (cmd == `SFP_OP_READ)) begin
        rd_req <= 1'b1;
        rd_addr <= full_addr;
      end else if (rise && (state == ST_DUMMY) && (rx_cnt == `SFP_DUMMY_BITS)) begin
        rd_req <= 1'b1;
        rd_addr <= addr;
      end else if (fall && (state == ST_RDATA)) begin
        drv <= 1'b1;
        so_out <= tx_byte[7];
        if (dual_out) begin
          si_out <= tx_byte[6];
          tx_shift <= {tx_byte[5:0], 2'b00};
          tx_cnt <= tx_cnt + 3'h2;
        end else begin
          tx_shift <= {tx_byte[6:0], 1'b0};
          tx_cnt <= tx_cnt + 3'h1;
        end
        // prefetch the following byte while this one shifts out
        if (tx_cnt == 3'h0) begin
          rd_req <= 1'b1;
          rd_addr <= rd_addr + 24'h000001;
        end
      end
    end
  end

  assign so_oe = sel & ~hold_act & drv & (state == ST_RDATA);
  // input pin drives only for dual read
  assign si_oe = so_oe & dual_out;

  // array request never gated by hold
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op_valid <= 1'b0;
      op_kind <= `SFP_KIND_ERASE_64K;
      op_addr <= 24'h000000;
      prot_fault <= 1'b0;
      wr_overrun <= 1'b0;
    end else if (clk_en) begin
      prot_fault <= 1'b0;
      if (op_valid && op_ready) begin
        op_valid <= 1'b0;
      end
      if (cs_fall) begin
        wr_overrun <= 1'b0;
      end
      // a byte with no room is dropped; set wins over the clear
      if (push_valid && !push_ready) begin
        wr_overrun <= 1'b1;
      end
      if (cs_rise && armed && is_op) begin
        if (target_prot) begin
          prot_fault <= 1'b1;
        end else if (!array_busy && !op_valid && (!is_prog || prog_ok)) begin
          op_valid <= 1'b1;
          op_addr <= addr;
          case (cmd)
            `SFP_OP_ERASE_64K: op_kind <= `SFP_KIND_ERASE_64K;
            `SFP_OP_ERASE_32K: op_kind <= `SFP_KIND_ERASE_32K;
            `SFP_OP_ERASE_4K: op_kind <= `SFP_KIND_ERASE_4K;
            `SFP_OP_CHIP_ERASE: op_kind <= `SFP_KIND_CHIP_ERASE;
            default: op_kind <= `SFP_KIND_PROGRAM;
          endcase
        end
      end
    end
  end

  sfp_pair_buf #(
    .W(8)
  ) u_wbuf (
    .ref_clk(ref_clk),
    .rst_sync_n(rst_sync_n),
    .clk_en(clk_en),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

endmodule // sfp_flash_pins

`default_nettype wire

// ==== testbench/sfp_flash_pins_checker.sv ====
`include "sfp_consts.vh"
`default_nettype none

module sfp_flash_pins_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic si_out,
  input wire logic si_oe,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [2:0] op_kind,
  input wire logic [23:0] op_addr,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] wr_data,
  input wire logic [31:0] sector_prot
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_deselect; cs_n [*5]; endsequence
  sequence s_paused; (!cs_n && !hold_n && !sck) [*6]; endsequence
  sequence s_op_wait; op_valid && !op_ready; endsequence
  sequence s_op_take; op_valid && op_ready; endsequence
  a_idle_float: assert property (s_deselect |-> !so_oe && !si_oe)
    else $error("pin driven while deselected");
  a_hold_float: assert property (s_paused |-> !so_oe && !si_oe)
    else $error("pin driven during hold");
  a_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so_out) |-> !$past(sck, 2))
    else $error("so_out moved off a falling edge");
  a_si_on_fall: assert property (si_oe && $past(si_oe) && $changed(si_out) |-> !$past(sck, 2))
    else $error("si_out moved off a falling edge");
  a_op_stable: assert property (s_op_wait |=> op_valid && $stable(op_kind) && $stable(op_addr))
    else $error("op request changed before taken");
  a_op_once: assert property (s_op_take |=> !op_valid)
    else $error("op request repeated");
  a_op_unprot: assert property ($rose(op_valid) && op_kind != `SFP_KIND_CHIP_ERASE |->
    !sector_prot[op_addr[`SFP_SECT_MSB:`SFP_SECT_LSB]])
    else $error("op issued to protected sector");
  a_wr_stall: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write byte dropped in stall");
  a_wp_lock: assert property (!wp_n [*6] |-> ($past(sector_prot) & ~sector_prot) == 32'h0)
    else $error("unprotect while write protect low");
endmodule // sfp_flash_pins_chk

bind sfp_flash_pins sfp_flash_pins_chk u_chk (.ref_clk, .rst_n, .cs_n, .sck, .hold_n, .wp_n,
  .si_out, .si_oe, .so_out, .so_oe, .op_valid, .op_ready, .op_kind, .op_addr, .wr_valid,
  .wr_ready, .wr_data, .sector_prot);

`default_nettype wire

// ==== testbench/sfp_spi_host.sv ====
`default_nettype none

module sfp_spi_host (
  input wire logic ref_clk,
  input wire logic si_pin,
  input wire logic so_pin,
  output var logic cs_n = 1'b1,
  output var logic sck = 1'b0,
  output var logic hold_n = 1'b1,
  output var logic wp_n = 1'b1,
  output var logic si_o = 1'b0,
  output var logic si_en = 1'b1,
  output var logic so_o = 1'b0,
  output var logic so_en = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic open();
    cs_n = 1'b0;
    tick(5);
  endtask
  task automatic close();
    tick(5);
    cs_n = 1'b1;
    so_en = 1'b0;
    // device lets go of the input pin a few cycles after deselect
    tick(5);
    si_en = 1'b1;
    tick(15);
  endtask
  task automatic pause();
    tick(2);
    hold_n = 1'b0;
    si_o = ~si_o;
    tick(8);
    sck = 1'b1;
    tick(5);
    sck = 1'b0;
    tick(8);
    hold_n = 1'b1;
    tick(5);
  endtask
  task automatic step(input logic [1:0] v, output logic [1:0] got);
    si_o = v[0];
    so_o = v[1];
    tick(5);
    got = {so_pin, si_pin};
    sck = 1'b1;
    tick(5);
    sck = 1'b0;
  endtask
  // second line joins in dual modes
  task automatic xfer(input logic [7:0] tx, input logic [1:0] m, input logic h,
      output logic [7:0] rx);
    logic [1:0] g;
    int i;
    si_en = (m != 2'd2);
    so_en = (m == 2'd1);
    for (i = 7; i >= 0; i = i - ((m == 2'd0) ? 1 : 2)) begin
      if (h && i == 3) pause();
      step((m == 2'd0) ? {1'b0, tx[i]} : tx[i -: 2], g);
      if (m == 2'd0) rx[i] = g[1];
      else rx[i -: 2] = g;
    end
  endtask
endmodule // sfp_spi_host

`default_nettype wire

// ==== testbench/serial_flash_pin_hold_dual_io_tb.sv ====
`include "sfp_consts.vh"
`default_nettype none

module serial_flash_pin_hold_dual_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n;
  logic so_last = 1'b0, si_last = 1'b0, stall = 1'b0;
  logic op_ready = 1'b0, wr_ready = 1'b0, rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [2:0] got_kind;
  logic [23:0] got_addr;
  logic [7:0] wrq [$];
  logic [7:0] txb [4];
  logic [7:0] rxb [4];
  int seed, n_errors, num_checks, n_faults;
  wire logic cs_n, sck, hold_n, wp_n, si_o, si_en, so_o, so_en;
  wire logic si_out, si_oe, so_out, so_oe, op_valid, wr_valid, rd_req, prot_fault, wr_overrun;
  wire logic [2:0] op_kind;
  wire logic [23:0] op_addr, rd_addr;
  wire logic [7:0] wr_data;
  wire logic [31:0] sector_prot;
  // released lines show a changing level, not a held one
  wire logic si_pin = si_oe ? si_out : (si_en ? si_o : ~si_last);
  wire logic so_pin = so_oe ? so_out : (so_en ? so_o : ~so_last);

  sfp_flash_pins u_dut (.ref_clk, .rst_n, .clk_en(1'b1), .cs_n, .sck, .si_in(si_pin), .si_out,
    .si_oe, .so_in(so_pin), .so_out, .so_oe, .hold_n, .wp_n, .op_valid, .op_ready, .op_kind,
    .op_addr, .array_busy(1'b0), .wr_valid, .wr_ready, .wr_data, .rd_req, .rd_addr, .rd_valid,
    .rd_data, .sector_prot, .prot_fault, .wr_overrun);
  sfp_spi_host u_host (.ref_clk, .si_pin, .so_pin, .cs_n, .sck, .hold_n, .wp_n, .si_o, .si_en,
    .so_o, .so_en);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] exp_rd(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  always @(posedge ref_clk) begin
    so_last <= so_pin;
    si_last <= si_pin;
    rd_valid <= #1 rd_req;
    if (rd_req) rd_data <= #1 exp_rd(rd_addr);
    op_ready <= #1 1'($random(seed));
    wr_ready <= #1 !stall && 1'($random(seed));
    if (op_valid && op_ready) begin
      got_kind <= op_kind;
      got_addr <= op_addr;
    end
    if (wr_valid && wr_ready) wrq.push_back(wr_data);
    if (prot_fault) n_faults++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na, input int n,
      input logic [1:0] m, input logic h);
    logic [7:0] r;
    int i;
    got_kind = 3'h7;
    u_host.open();
    u_host.xfer(op, 2'd0, 1'b0, r);
    for (i = na - 1; i >= 0; i--) u_host.xfer(a[i*8 +: 8], 2'd0, 1'b0, r);
    if (m == 2'd2) u_host.xfer(8'h00, 2'd0, 1'b0, r);
    for (i = 0; i < n; i++) u_host.xfer(txb[i], m, h, rxb[i]);
    u_host.close();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  initial begin
    logic [7:0] ops [4];
    logic [23:0] a;
    int k, s;
    seed = 32'h55BE3776;
    rst_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    u_host.tick(6);
    chk("sector_prot", 32'hFFFFFFFF, sector_prot);
    chk("so_oe", 32'h0, so_oe);
    frame(`SFP_OP_ERASE_4K, 24'h030000, 3, 0, 2'd0, 1'b0);
    chk("prot_fault", 32'h1, n_faults);
    chk("refused op", 32'h7, got_kind);
    for (s = 0; s < 32; s++) frame(`SFP_OP_UNPROTECT, {3'h0, 5'(s), 16'h0}, 3, 0, 2'd0, 1'b0);
    chk("sector_prot", 32'h0, sector_prot);
    ops = '{`SFP_OP_ERASE_64K, `SFP_OP_ERASE_32K, `SFP_OP_ERASE_4K, `SFP_OP_CHIP_ERASE};
    for (k = 0; k < 4; k++) begin
      a = 24'($random(seed)) & 24'h1F0000;
      frame(ops[k], a, (k == 3) ? 0 : 3, 0, 2'd0, 1'b0);
      chk("op_kind", k, got_kind);
      if (k < 3) chk("op_addr", a, got_addr);
    end
    for (k = 0; k < 2; k++) begin
      a = 24'($random(seed)) & 24'h1FFFFF;
      for (s = 0; s < 3; s++) txb[s] = 8'($random(seed));
      wrq.delete();
      frame(k ? `SFP_OP_DUAL_PROGRAM : `SFP_OP_PROGRAM, a, 3, 3, 2'(k), 1'(k));
      chk("op_kind", `SFP_KIND_PROGRAM, got_kind);
      chk("op_addr", a, got_addr);
      for (s = 0; s < 3; s++) chk("wr_data", txb[s], wrq[s]);
    end
    // receiver stalls: third byte has nowhere to go
    stall = 1'b1;
    wrq.delete();
    frame(`SFP_OP_PROGRAM, 24'h040000, 3, 3, 2'd0, 1'b0);
    chk("wr_overrun", 32'h1, wr_overrun);
    stall = 1'b0;
    u_host.tick(40);
    chk("kept bytes", 32'h2, wrq.size());
    for (k = 0; k < 2; k++) begin
      a = 24'($random(seed));
      frame(k ? `SFP_OP_DUAL_READ : `SFP_OP_READ, a, 3, 3, k ? 2'd2 : 2'd0, !k);
      for (s = 0; s < 3; s++) chk("read byte", exp_rd(a + 24'(s)), rxb[s]);
    end
    chk("wr_overrun", 32'h0, wr_overrun);
    u_host.wp_n = 1'b0;
    frame(`SFP_OP_PROTECT, 24'h050000, 3, 0, 2'd0, 1'b0);
    frame(`SFP_OP_UNPROTECT, 24'h050000, 3, 0, 2'd0, 1'b0);
    chk("sector_prot", 32'h20, sector_prot);
    frame(`SFP_OP_ERASE_64K, 24'h050000, 3, 0, 2'd0, 1'b0);
    chk("prot_fault", 32'h2, n_faults);
    test_done();
  end
endmodule // serial_flash_pin_hold_dual_io_tb

`default_nettype wire
